// file: logic/mtx_pkg.sv
// constants, field layout and types for the transmit association context
package mtx_pkg;

	// register byte addresses
	localparam logic [15:0] MTX_CAP_ADDR    = 16'hB000;
	localparam logic [15:0] MTX_CTRL_ADDR   = 16'hB004;
	localparam logic [15:0] MTX_SEL_ADDR    = 16'hB010;
	localparam logic [15:0] MTX_PN0_ADDR    = 16'hB018;
	localparam logic [15:0] MTX_PN1_ADDR    = 16'hB01C;
	localparam logic [15:0] MTX_KEY0_ADDR   = 16'hB020;
	localparam logic [15:0] MTX_KEY_IDX_MSK = 16'h000C;
	localparam int          MTX_KEY_IDX_LSB = 2;
	localparam int          MTX_KEY_WORDS   = 4;

	// tx_assoc_select fields
	localparam int MTX_AN0_LSB = 0;
	localparam int MTX_AN1_LSB = 2;
	localparam int MTX_SEL_BIT = 4;
	localparam int MTX_ACT_BIT = 5;

	// tx_protect_control fields
	localparam int          MTX_MODE_LSB    = 0;
	localparam int          MTX_INCDIS_BIT  = 2;
	localparam int          MTX_THR_LSB     = 8;
	localparam logic [23:0] MTX_THR_RST     = 24'h000007;
	localparam logic [7:0]  MTX_THR_LOW     = 8'hFF;

	// packet number limits
	localparam logic [31:0] MTX_PN_STOP     = 32'h0000FFFF;
	localparam logic [31:0] MTX_PN_LAST     = 32'h0000FFF0;
	localparam logic [31:0] MTX_PN_RST      = 32'h00000000;

	typedef enum logic [1:0] {
		MTX_MODE_OFF   = 2'h0,
		MTX_MODE_INTEG = 2'h1,
		MTX_MODE_ENC   = 2'h2,
		MTX_MODE_RSVD  = 2'h3
	} mtx_mode_t;

	typedef enum logic {
		MTX_IDLE = 1'h0,
		MTX_BUSY = 1'h1
	} mtx_fsm_t;

endpackage : mtx_pkg

// file: logic/mtx_rst_sync.sv
// two-stage release of the asynchronous reset
`timescale 1ns/1ps
module mtx_rst_sync (
	input  wire logic clk,
	input  wire logic rst_b,
	output logic      rst_sync_b
);
	typedef struct packed {
		logic [1:0] stage;
	} mtx_rs_st_t;

	mtx_rs_st_t s_r;
	mtx_rs_st_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.stage = {s_r.stage[0], 1'b1};
	end

	// assertion is immediate, release waits two edges
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rst_sync_b = s_r.stage[1];

endmodule : mtx_rst_sync

// file: logic/mtx_pn_counter.sv
// one packet-number register with load and single step
`timescale 1ns/1ps
module mtx_pn_counter
	import mtx_pkg::*;
#(
	parameter int W = 32
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	input  wire logic         step,
	output logic      [W-1:0] count
);
	typedef struct packed {
		logic [W-1:0] pn;
	} mtx_pc_st_t;

	mtx_pc_st_t s_r;
	mtx_pc_st_t s_nxt;

	// a software load wins: it is how a new association gets its start value
	always_comb begin
		s_nxt = s_r;
		if (load) begin
			s_nxt.pn = load_val;
		end else if (step) begin
			s_nxt.pn = s_r.pn + {{(W-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r.pn <= MTX_PN_RST[W-1:0];
		end else begin
			s_r <= s_nxt;
		end
	end

	assign count = s_r.pn;

endmodule : mtx_pn_counter

// file: logic/mtx_tx_sa_control.sv
// transmit association context: select, packet numbers, key 0, register port
//
// How it works
// - two 2-bit association numbers; active one goes into frame header
// - select bit picks association 0 or 1, applied only at packet start
// - read-only active flag copies select bit at each packet boundary
// - one 32-bit packet number per association, active one goes into header
// - each packet sent advances its own association's packet number by one unless increments are disabled
// - exhaustion pulse when active packet number reaches the threshold
// - threshold is programmable upper 24 bits with low byte all ones
// - no packet is sent once packet number reached 0xFFFF
// - after sending packet number 0xFFF0 protection mode falls to off
// - mode 00 off, 01 integrity only, 10 encrypt plus integrity, 11 reserved
// - 128-bit key 0 written as four words, word 0 lowest bits
// - key words are write-only, reading them returns zero
// - a readable byte-wise XOR summary of the key checks programming
// - packet numbers stored and read, key words stored, without byte swapping
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
module mtx_tx_sa_control
	import mtx_pkg::*;
#(
	parameter int AW = 16
) (
	input  wire logic          clk,
	input  wire logic          rst_b,
	input  wire logic [AW-1:0] reg_addr,
	input  wire logic [31:0]   reg_wdata,
	input  wire logic          reg_wr,
	input  wire logic          reg_rd,
	output logic      [31:0]   reg_rdata,
	input  wire logic          pkt_start,
	input  wire logic          pkt_done,
	output logic               tx_permit,
	output logic               frame_active,
	output logic               hdr_sa,
	output logic      [1:0]    hdr_an,
	output logic      [31:0]   hdr_pn,
	output logic      [127:0]  tx_key0,
	output logic      [1:0]    protect_mode,
	output logic               integ_en,
	output logic               encrypt_en,
	output logic               active_assoc_flag,
	output logic               pn_exhaustion_irq
);

	////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [1:0]   an0;
		logic [1:0]   an1;
		logic         sel;
		logic         act;
		mtx_fsm_t     fsm;
		logic         frame_sa;
		logic [1:0]   hdr_an;
		logic [31:0]  hdr_pn;
		mtx_mode_t    mode;
		logic         inc_dis;
		logic [23:0]  thr;
		logic [127:0] key;
		logic [31:0]  rdata;
		logic         irq;
	} mtx_main_st_t;

	mtx_main_st_t s_r;
	mtx_main_st_t s_nxt;

	logic        rst_n;
	logic [31:0] pn0;
	logic [31:0] pn1;
	logic [31:0] pn_next_sa;
	logic [31:0] pn_frame;
	logic [31:0] pn_bumped;
	logic [31:0] thr_full;
	logic [7:0]  key_sum;
	logic        start_ok;
	logic        done_ok;
	logic        step0;
	logic        step1;
	logic        wr_pn0;
	logic        wr_pn1;
	logic        key_hit;

	mtx_rst_sync u_rst (
		.clk        (clk),
		.rst_b      (rst_b),
		.rst_sync_b (rst_n)
	);

	////////////////////////////////////////////////////////////////////////////
	// packet numbers

	assign wr_pn0 = reg_wr && (reg_addr == MTX_PN0_ADDR);
	assign wr_pn1 = reg_wr && (reg_addr == MTX_PN1_ADDR);

	// increment disable can freeze the counters
	assign done_ok = (s_r.fsm == MTX_BUSY) && pkt_done;
	assign step0   = done_ok && !s_r.inc_dis && (s_r.frame_sa == 1'b0);
	assign step1   = done_ok && !s_r.inc_dis && (s_r.frame_sa == 1'b1);

	mtx_pn_counter #(.W(32)) u_pn0 (
		.clk      (clk),
		.rst_n    (rst_n),
		.load     (wr_pn0),
		.load_val (reg_wdata),
		.step     (step0),
		.count    (pn0)
	);

	mtx_pn_counter #(.W(32)) u_pn1 (
		.clk      (clk),
		.rst_n    (rst_n),
		.load     (wr_pn1),
		.load_val (reg_wdata),
		.step     (step1),
		.count    (pn1)
	);

	assign pn_next_sa = s_r.sel ? pn1 : pn0;
	assign pn_frame   = s_r.frame_sa ? pn1 : pn0;
	assign pn_bumped  = pn_frame + 32'h00000001;
	assign thr_full   = {s_r.thr, MTX_THR_LOW};

	// a frame may only open while its number is below the stop value
	assign tx_permit = (pn_next_sa < MTX_PN_STOP);
	assign start_ok  = (s_r.fsm == MTX_IDLE) && pkt_start && tx_permit;

	////////////////////////////////////////////////////////////////////////////
	// key summary

	function automatic logic [7:0] mtx_xor_bytes(input logic [127:0] k);
		logic [7:0] acc;
		acc = 8'h00;
		for (int i = 0; i < 16; i++) begin
			acc = acc ^ k[i*8 +: 8];
		end
		return acc;
	endfunction : mtx_xor_bytes

	assign key_sum = mtx_xor_bytes(s_r.key);
	assign key_hit = (reg_addr & ~MTX_KEY_IDX_MSK) == MTX_KEY0_ADDR;

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		s_nxt     = s_r;
		s_nxt.irq = 1'b0;

		// register writes
		if (reg_wr) begin
			case (reg_addr)
				MTX_SEL_ADDR: begin
					s_nxt.an0 = reg_wdata[MTX_AN0_LSB +: 2];
					s_nxt.an1 = reg_wdata[MTX_AN1_LSB +: 2];
					s_nxt.sel = reg_wdata[MTX_SEL_BIT];
				end
				MTX_CTRL_ADDR: begin
					s_nxt.mode    = mtx_mode_t'(reg_wdata[MTX_MODE_LSB +: 2]);
					s_nxt.inc_dis = reg_wdata[MTX_INCDIS_BIT];
					s_nxt.thr     = reg_wdata[MTX_THR_LSB +: 24];
				end
				default: begin
				end
			endcase
			if (key_hit) begin
				// stored as written, no byte reordering
				s_nxt.key[reg_addr[MTX_KEY_IDX_LSB +: 2]*32 +: 32] = reg_wdata;
			end
		end

		// frame sequencing; active flag only moves at a boundary
		case (s_r.fsm)
			MTX_IDLE: begin
				if (start_ok) begin
					s_nxt.fsm      = MTX_BUSY;
					s_nxt.act      = s_r.sel;
					s_nxt.frame_sa = s_r.sel;
					s_nxt.hdr_an   = s_r.sel ? s_r.an1 : s_r.an0;
					s_nxt.hdr_pn   = pn_next_sa;
				end
			end
			MTX_BUSY: begin
				// header fields hold for the whole frame
				if (pkt_done) begin
					s_nxt.fsm = MTX_IDLE;
					if (!s_r.inc_dis && (pn_bumped == thr_full)) begin
						s_nxt.irq = 1'b1;
					end
					// hardware clear wins over a same-cycle control write
					if (s_r.hdr_pn == MTX_PN_LAST) begin
						s_nxt.mode = MTX_MODE_OFF;
					end
				end
			end
			default: begin
				s_nxt.fsm = MTX_IDLE;
			end
		endcase

		// read data, valid in the cycle after the strobe only
		s_nxt.rdata = 32'h00000000;
		if (reg_rd) begin
			case (reg_addr)
				MTX_SEL_ADDR: begin
					s_nxt.rdata[MTX_AN0_LSB +: 2] = s_r.an0;
					s_nxt.rdata[MTX_AN1_LSB +: 2] = s_r.an1;
					s_nxt.rdata[MTX_SEL_BIT]      = s_r.sel;
					s_nxt.rdata[MTX_ACT_BIT]      = s_r.act;
				end
				MTX_CTRL_ADDR: begin
					s_nxt.rdata[MTX_MODE_LSB +: 2] = s_r.mode;
					s_nxt.rdata[MTX_INCDIS_BIT]    = s_r.inc_dis;
					s_nxt.rdata[MTX_THR_LSB +: 24] = s_r.thr;
				end
				MTX_PN0_ADDR: begin
					s_nxt.rdata = pn0;
				end
				MTX_PN1_ADDR: begin
					s_nxt.rdata = pn1;
				end
				MTX_CAP_ADDR: begin
					s_nxt.rdata[7:0] = key_sum;
				end
				default: begin
					// key words and unmapped addresses read zero
					s_nxt.rdata = 32'h00000000;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r       <= '0;
			s_r.fsm   <= MTX_IDLE;
			s_r.mode  <= MTX_MODE_OFF;
			s_r.thr   <= MTX_THR_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign reg_rdata         = s_r.rdata;
	assign frame_active      = (s_r.fsm == MTX_BUSY);
	assign hdr_sa            = s_r.frame_sa;
	assign hdr_an            = s_r.hdr_an;
	assign hdr_pn            = s_r.hdr_pn;
	assign tx_key0           = s_r.key;
	assign protect_mode      = s_r.mode;
	assign integ_en          = (s_r.mode == MTX_MODE_INTEG) || (s_r.mode == MTX_MODE_ENC);
	assign encrypt_en        = (s_r.mode == MTX_MODE_ENC);
	assign active_assoc_flag = s_r.act;
	assign pn_exhaustion_irq = s_r.irq;

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking mtx_cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	AST_AN_INSERT: assert property (
		start_ok |=> hdr_an == ($past(s_r.sel) ? $past(s_r.an1) : $past(s_r.an0)))
		else $error("header association number not taken from selected association");

	AST_SEL_AT_BOUNDARY: assert property (
		start_ok |=> (hdr_sa == $past(s_r.sel)) && (active_assoc_flag == $past(s_r.sel)))
		else $error("select bit not applied at packet start");

	AST_ACT_ONLY_AT_BOUNDARY: assert property (
		!start_ok |=> $stable(active_assoc_flag))
		else $error("active flag moved without a packet boundary");

	AST_PN_INSERT: assert property (
		start_ok |=> hdr_pn == $past(pn_next_sa))
		else $error("header packet number not the active association value");

	AST_PN0_ADVANCE: assert property (
		done_ok && !s_r.inc_dis && !hdr_sa && !wr_pn0 |=> pn0 == $past(pn0) + 32'h00000001)
		else $error("association 0 packet number did not advance by one");

	AST_PN1_ADVANCE: assert property (
		done_ok && !s_r.inc_dis && hdr_sa && !wr_pn1 |=> pn1 == $past(pn1) + 32'h00000001)
		else $error("association 1 packet number did not advance by one");

	AST_EXHAUST_IRQ: assert property (
		done_ok && !s_r.inc_dis && (pn_bumped == {s_r.thr, MTX_THR_LOW})
		|=> pn_exhaustion_irq ##1 !pn_exhaustion_irq)
		else $error("exhaustion pulse missing or too long");

	AST_NO_TX_AFTER_STOP: assert property (
		pn_next_sa >= MTX_PN_STOP && !frame_active |=> !frame_active)
		else $error("frame opened with packet number at or past the stop value");

	AST_AUTO_OFF: assert property (
		done_ok && (hdr_pn == MTX_PN_LAST) |=> protect_mode == MTX_MODE_OFF)
		else $error("protection mode not cleared after last allowed packet");

	AST_KEY_READ_ZERO: assert property (
		reg_rd && key_hit |=> reg_rdata == 32'h00000000)
		else $error("key word read returned non-zero data");

	AST_FRAME_HOLD: assert property (
		frame_active && !pkt_done |=> $stable(hdr_sa) && $stable(hdr_an) && $stable(hdr_pn))
		else $error("header fields changed inside a frame");

	AST_KEY_WORD0: assert property (
		reg_wr && key_hit && (reg_addr[MTX_KEY_IDX_LSB +: 2] == 2'h0)
		|=> tx_key0[31:0] == $past(reg_wdata))
		else $error("key word 0 did not land in the lowest key bits");

	AST_KEY_WORD3: assert property (
		reg_wr && key_hit && (reg_addr[MTX_KEY_IDX_LSB +: 2] == 2'h3)
		|=> tx_key0[127:96] == $past(reg_wdata))
		else $error("key word 3 did not land in the highest key bits");

	AST_KEY_SUM_READ: assert property (
		reg_rd && (reg_addr == MTX_CAP_ADDR) |=> reg_rdata == {24'h000000, $past(key_sum)})
		else $error("capability read did not return the key summary");

	AST_PN_READ: assert property (
		reg_rd && (reg_addr == MTX_PN0_ADDR) |=> reg_rdata == $past(pn0))
		else $error("packet number read not returned unchanged");

	AST_MODE_DECODE: assert property (
		(protect_mode == MTX_MODE_OFF) || (protect_mode == MTX_MODE_RSVD)
		|-> !integ_en && !encrypt_en)
		else $error("protection enabled in off or reserved mode");

	AST_NO_STEP_DISABLED: assert property (
		done_ok && s_r.inc_dis && !wr_pn0 && !wr_pn1 |=> $stable(pn0) && $stable(pn1))
		else $error("packet number moved while increments are disabled");

	COV_INC_DIS: cover property (done_ok && s_r.inc_dis);
	COV_SWITCH: cover property (start_ok && (s_r.sel != s_r.act));
	COV_IRQ: cover property (pn_exhaustion_irq);
	COV_AUTO_OFF: cover property (done_ok && (hdr_pn == MTX_PN_LAST));
	COV_SEL_MID_FRAME: cover property (frame_active && reg_wr && (reg_addr == MTX_SEL_ADDR));

endmodule : mtx_tx_sa_control

// file: sim/tb_mtx_tx_sa_control.sv
// self-checking bench for the transmit association context
`timescale 1ns/1ps
module tb_mtx_tx_sa_control import mtx_pkg::*;;

	logic          clk;
	logic          rst_b;
	logic [15:0]   reg_addr;
	logic [31:0]   reg_wdata;
	logic          reg_wr;
	logic          reg_rd;
	logic [31:0]   reg_rdata;
	logic          pkt_start;
	logic          pkt_done;
	logic          tx_permit;
	logic          frame_active;
	logic          hdr_sa;
	logic [1:0]    hdr_an;
	logic [31:0]   hdr_pn;
	logic [127:0]  tx_key0;
	logic [1:0]    protect_mode;
	logic          integ_en;
	logic          encrypt_en;
	logic          active_assoc_flag;
	logic          pn_exhaustion_irq;
	int            errors;
	int            check_count;
	logic [31:0]   d;

	mtx_tx_sa_control #(.AW(16)) i_mtx_tx_sa_control (
		.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.pkt_start(pkt_start), .pkt_done(pkt_done), .tx_permit(tx_permit),
		.frame_active(frame_active), .hdr_sa(hdr_sa), .hdr_an(hdr_an), .hdr_pn(hdr_pn),
		.tx_key0(tx_key0), .protect_mode(protect_mode), .integ_en(integ_en),
		.encrypt_en(encrypt_en), .active_assoc_flag(active_assoc_flag),
		.pn_exhaustion_irq(pn_exhaustion_irq)
	);

	always #50 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////////
	task automatic summarize;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : summarize

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// one idle cycle between accesses keeps each strobe to one assignment per step
	task automatic wr(input logic [15:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_wr    <= 1'h1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'h0;
		// let the write settle before anyone looks at the outputs
		#1;
	endtask : wr

	task automatic rd(input logic [15:0] a, output logic [31:0] v);
		@(posedge clk);
		reg_rd   <= 1'h1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1 v = reg_rdata;
	endtask : rd

	task automatic rchk(input string what, input logic [15:0] a, input logic [31:0] exp);
		logic [31:0] v;
		rd(a, v);
		chk(what, exp, v);
	endtask : rchk

	task automatic pulse(input bit done);
		@(posedge clk);
		if (done) pkt_done <= 1'h1;
		else pkt_start <= 1'h1;
		@(posedge clk);
		pkt_done  <= 1'h0;
		pkt_start <= 1'h0;
		#1;
	endtask : pulse

	task automatic hdr(input logic sa, input logic [1:0] an, input logic [31:0] pn);
		chk("frame_active", 32'h1, {31'h0, frame_active});
		chk("hdr_sa", {31'h0, sa}, {31'h0, hdr_sa});
		chk("hdr_an", {30'h0, an}, {30'h0, hdr_an});
		chk("hdr_pn", pn, hdr_pn);
		chk("active_flag", {31'h0, sa}, {31'h0, active_assoc_flag});
	endtask : hdr

	////////////////////////////////////////////////////////////////////////////////
	// a hang anywhere ends the run through the same report
	initial begin
		repeat (5000) @(posedge clk);
		errors++;
		summarize();
	end

	initial begin
		clk = 1'h0; rst_b = 1'h0; reg_addr = 16'h0; reg_wdata = 32'h0;
		reg_wr = 1'h0; reg_rd = 1'h0; pkt_start = 1'h0; pkt_done = 1'h0;
		errors = 0; check_count = 0;
		repeat (4) @(posedge clk);
		rst_b <= 1'h1;
		repeat (3) @(posedge clk);
		rchk("sel_reset", MTX_SEL_ADDR, 32'h0);
		rchk("pn0_reset", MTX_PN0_ADDR, 32'h0);
		rchk("pn1_reset", MTX_PN1_ADDR, 32'h0);
		rchk("ctrl_reset", MTX_CTRL_ADDR, 32'h00000700);
		wr(16'hB100, 32'h12345678);
		rchk("unmapped", 16'hB100, 32'h0);
		// associations, packet numbers, boundary switching
		wr(MTX_SEL_ADDR, 32'h00000009);
		wr(MTX_PN0_ADDR, 32'h00000005);
		wr(MTX_PN1_ADDR, 32'h00000100);
		pulse(0);
		hdr(1'h0, 2'h1, 32'h5);
		wr(MTX_SEL_ADDR, 32'h00000019);
		rchk("sel_mid", MTX_SEL_ADDR, 32'h00000019);
		chk("hdr_sa_mid", 32'h0, {31'h0, hdr_sa});
		pulse(1);
		chk("frame_end", 32'h0, {31'h0, frame_active});
		rchk("pn0_step", MTX_PN0_ADDR, 32'h00000006);
		rchk("sel_idle", MTX_SEL_ADDR, 32'h00000019);
		pulse(0);
		hdr(1'h1, 2'h2, 32'h100);
		rchk("sel_act", MTX_SEL_ADDR, 32'h00000039);
		pulse(1);
		rchk("pn1_step", MTX_PN1_ADDR, 32'h00000101);
		rchk("pn0_keep", MTX_PN0_ADDR, 32'h00000006);
		// key words, write-only, summary
		for (int i = 0; i < MTX_KEY_WORDS; i++) begin
			d = {8'(4 * i + 3), 8'(4 * i + 2), 8'(4 * i + 1), 8'(4 * i)};
			if (i == 3) d[7:0] = 8'h1C;
			wr(MTX_KEY0_ADDR + 16'(4 * i), d);
			chk("key_word", d, tx_key0[32 * i +: 32]);
			rchk("key_read", MTX_KEY0_ADDR + 16'(4 * i), 32'h0);
		end
		rd(MTX_CAP_ADDR, d);
		chk("key_sum", 32'h00000010, d);
		// every mode code
		for (int m = 0; m < 4; m++) begin
			wr(MTX_CTRL_ADDR, 32'h00000700 | 32'(m));
			rchk("ctrl_mode", MTX_CTRL_ADDR, 32'h00000700 | 32'(m));
			chk("mode", 32'(m), {30'h0, protect_mode});
			chk("integ_en", {31'h0, m == 1 || m == 2}, {31'h0, integ_en});
			chk("encrypt_en", {31'h0, m == 2}, {31'h0, encrypt_en});
		end
		// exhaustion at threshold {0x000001, 0xFF}
		wr(MTX_SEL_ADDR, 32'h00000009);
		wr(MTX_CTRL_ADDR, 32'h00000102);
		wr(MTX_PN0_ADDR, 32'h000001FE);
		pulse(0);
		hdr(1'h0, 2'h1, 32'h1FE);
		pulse(1);
		chk("irq_hit", 32'h1, {31'h0, pn_exhaustion_irq});
		@(posedge clk);
		#1 chk("irq_pulse", 32'h0, {31'h0, pn_exhaustion_irq});
		// last allowed number turns protection off
		wr(MTX_PN0_ADDR, 32'h0000FFF0);
		pulse(0);
		hdr(1'h0, 2'h1, 32'h0000FFF0);
		chk("mode_mid", 32'h2, {30'h0, protect_mode});
		pulse(1);
		chk("mode_off", 32'h0, {30'h0, protect_mode});
		rchk("ctrl_off", MTX_CTRL_ADDR, 32'h00000100);
		rchk("pn0_fff1", MTX_PN0_ADDR, 32'h0000FFF1);
		// increment disable freezes the number, a done while idle is ignored
		wr(MTX_CTRL_ADDR, 32'h00000104);
		pulse(0);
		hdr(1'h0, 2'h1, 32'h0000FFF1);
		pulse(1);
		rchk("pn0_frozen", MTX_PN0_ADDR, 32'h0000FFF1);
		wr(MTX_CTRL_ADDR, 32'h00000100);
		pulse(1);
		rchk("pn0_idle_done", MTX_PN0_ADDR, 32'h0000FFF1);
		// stop value refuses any further frame
		wr(MTX_PN0_ADDR, MTX_PN_STOP);
		chk("permit_off", 32'h0, {31'h0, tx_permit});
		pulse(0);
		chk("no_frame", 32'h0, {31'h0, frame_active});
		wr(MTX_PN0_ADDR, 32'h0000FFFE);
		chk("permit_on", 32'h1, {31'h0, tx_permit});
		summarize();
	end

endmodule : tb_mtx_tx_sa_control
